// *** dv/i2c_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  // Resolved wire levels
  input  wire logic sclW,
  input  wire logic sdaW,
  // Pull-downs of this master, high to pull
  output var  logic sclLow,
  output var  logic sdaLow
);
  localparam int Half = 1250; // Half a bit at 400 kbit/s, in ns
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // Release the clock, then wait out any stretch; bounded so a stuck target cannot hang us
  task automatic sclUp();
    sclLow = 1'b0;
    for (int i = 0; i < 500 && sclW !== 1'b1; i++) #10;
    #Half;
  endtask
  // One pulse: data moves only while the clock is low, sampled late in high
  task automatic bitIo(input logic b, output logic s);
    #200 sdaLow = !b;
    #(Half - 200);
    sclUp();
    s = sdaW;
    sclLow = 1'b1;
  endtask
  task automatic start();
    #200 sdaLow = 1'b0;
    #Half;
    sclUp();
    sdaLow = 1'b1;
    #Half sclLow = 1'b1;
  endtask
  task automatic stop();
    #200 sdaLow = 1'b1;
    #Half;
    sclUp();
    sdaLow = 1'b0;
    #Half;
  endtask
  // Eight bits MSB first, then the ninth pulse made here
  task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitIo(d[i], s);
      q[i] = s;
    end
    bitIo(ackIn, ack);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// *** dv/test_video_decoder_i2c_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_video_decoder_i2c_slave_port;
  logic                    core_clk, resetn, linkClk, strap, mScl, mSda;
  logic                    sclOut, sclOe, sdaOut, sdaOe, regStrobe;
  logic [7:0]              regRdData;
  logic [7:0]              mem [256];
  logic [7:0]              pat [3] = '{8'ha5, 8'h5a, 8'hc3};
  video_i2c_pkg::reg_req_s regReq;
  int                      errors, total_checks;
  // Pull-ups: a released wire reads high
  wire logic               sclW = !(sclOe || mScl);
  wire logic               sdaW = !(sdaOe || mSda);

  // Link clock rising edges never line up with core rising edges
  always #5 core_clk = ~core_clk;
  always #6 linkClk = ~linkClk;

  // Register map stand-in
  always @(posedge core_clk) begin
    if (regStrobe && regReq.write) begin
      mem[regReq.addr] <= regReq.data;
    end
  end
  assign regRdData = mem[regReq.addr];

  video_decoder_i2c_slave_port video_decoder_i2c_slave_port_inst (
    .core_clk(core_clk), .resetn(resetn), .linkClk(linkClk), .sclIn(sclW), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .bus_address_strap(strap),
    .regStrobe(regStrobe), .regReq(regReq), .regRdData(regRdData));
  i2c_host_model i2c_host_model_inst (.sclW(sclW), .sdaW(sdaW), .sclLow(mScl), .sdaLow(mSda));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset with a strap level; settle long enough for the strap to be taken
  task automatic rst(input logic s);
    @(posedge core_clk);
    #1 resetn = 1'b0;
    strap = s;
    repeat (10) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (30) @(posedge core_clk);
    #1;
  endtask
  // Send one byte and compare the acknowledge slot (0 = acknowledged)
  task automatic put(input logic [7:0] d, input logic a);
    logic [7:0] q;
    logic       s;
    i2c_host_model_inst.xfer(d, 1'b1, q, s);
    check({7'h0, s}, {7'h0, a});
  endtask
  // Only the strapped address answers, even after the pin changes to pixel use
  task automatic tAddr(input logic s);
    rst(s);
    strap = !s;
    for (int i = 0; i < 2; i++) begin
      i2c_host_model_inst.start();
      put(i ? 8'hba : 8'hb8, (i == s) ? 1'b0 : 1'b1);
      i2c_host_model_inst.stop();
      check({6'h00, sclOe, sdaOe}, 8'h00);
    end
  endtask
  // Burst across the top of the map, so the pointer wraps to 00h
  task automatic tBurst();
    rst(1'b0);
    i2c_host_model_inst.start();
    put(8'hb8, 1'b0);
    put(8'hfe, 1'b0);
    for (int i = 0; i < 3; i++) begin
      put(pat[i], 1'b0);
    end
    i2c_host_model_inst.stop();
    for (int i = 0; i < 3; i++) begin
      check(mem[8'(8'hfe + i)], pat[i]);
    end
  endtask
  // Two-phase read of the same bytes; the last is left unacknowledged
  task automatic tRead();
    logic [7:0] q;
    logic       s;
    i2c_host_model_inst.start();
    put(8'hb8, 1'b0);
    put(8'hfe, 1'b0);
    i2c_host_model_inst.stop();
    i2c_host_model_inst.start();
    put(8'hb9, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i2c_host_model_inst.xfer(8'hff, i == 2, q, s);
      check(q, pat[i]);
    end
    i2c_host_model_inst.stop();
  endtask

  // Main sequence
  initial begin
    core_clk = 1'b0;
    linkClk = 1'b0;
    resetn = 1'b0;
    strap = 1'b0;
    errors = 0;
    total_checks = 0;
    tAddr(1'b0);
    tAddr(1'b1);
    tBurst();
    tRead();
    results();
  end
  // Watchdog at about two and a half times the expected run
  initial begin
    #1000000;
    errors++;
    results();
  end
endmodule // test_video_decoder_i2c_slave_port
`default_nettype wire

// *** dv/video_i2c_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module video_i2c_port_chk (
  // Clocks and reset
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire logic                    linkClk,
  // Bus wires, drives and strap
  input wire logic                    sclIn,
  input wire logic                    sclOut,
  input wire logic                    sclOe,
  input wire logic                    sdaIn,
  input wire logic                    sdaOut,
  input wire logic                    sdaOe,
  input wire logic                    bus_address_strap,
  // Register side
  input wire logic                    regStrobe,
  input wire video_i2c_pkg::reg_req_s regReq,
  input wire logic [7:0]              regRdData
);
  // Open-drain pins may only ever pull low
  AST_PINS_LOW: assert property (
    @(posedge linkClk) disable iff (!resetn) !sclOut && !sdaOut) else $error("pin out high");
  // Pulling data low with the clock high would fake a start
  AST_NO_START: assert property (
    @(posedge linkClk) disable iff (!resetn) $rose(sdaOe) |-> !sclIn) else $error("sda in high");
  AST_DATA_STABLE: assert property (
    @(posedge linkClk) disable iff (!resetn) sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("sda moved in high");
  // A stretch starts in the low phase and ends within a bounded wait
  AST_STRETCH_LOW: assert property (
    @(posedge linkClk) disable iff (!resetn) $rose(sclOe) |-> !sclIn) else $error("bad stretch");
  AST_STRETCH_END: assert property (
    @(posedge linkClk) disable iff (!resetn) $rose(sclOe) |-> ##[1:40] !sclOe)
    else $error("stretch too long");
  // Register accesses are single pulses, made only while the bus is held
  AST_STRB_PULSE: assert property (
    @(posedge core_clk) disable iff (!resetn) regStrobe |=> !regStrobe) else $error("long strobe");
  AST_REQ_HOLD: assert property (
    @(posedge core_clk) disable iff (!resetn) !regStrobe |-> $stable(regReq))
    else $error("request moved");
  AST_STRB_STRETCH: assert property (
    @(posedge core_clk) disable iff (!resetn) regStrobe |-> sclOe) else $error("no stretch");
endmodule // video_i2c_port_chk

bind video_decoder_i2c_slave_port video_i2c_port_chk chk_inst (.core_clk(core_clk),
  .resetn(resetn), .linkClk(linkClk), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .bus_address_strap(bus_address_strap),
  .regStrobe(regStrobe), .regReq(regReq), .regRdData(regRdData));
`default_nettype wire

// *** verilog/video_decoder_i2c_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "video_i2c_regs.svh"

// Summary of operation
// - The port is a bus target only and never drives start, stop or a transfer of its own.
// - The port answers write address B8h with the strap low and BAh with the strap high.
// - The strap is sampled once after reset and the chosen address never changes after that.
// - Bus traffic up to 400 kbit/s is handled, since the lines are oversampled by the link clock.
// - Both lines high is the free bus and the port releases both lines whenever idle.
// - The port changes its data line only after it has seen the clock line go low.
// - Data falling with clock high is a start and data rising with clock high is a stop.
// - Every byte is eight bits then one acknowledge bit, with no limit on bytes per transfer.
// - After the address come a subaddress and data bytes that are stored from that subaddress on.
// - The port acknowledges the address, the subaddress and every data byte of a write.
// - A read is a subaddress-only write ended by stop, then a start with the odd read address.
// - In a read the port returns bytes until the master leaves one unacknowledged and stops.
// - The port holds the clock line low while the register map finishes each access.
module video_decoder_i2c_slave_port (
  // Core side clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // Oversampling clock of the bus engine
  input  wire logic                  linkClk,
  // Two-wire bus, open drain
  input  wire logic                  sclIn,
  output logic                       sclOut,
  output logic                       sclOe,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  // Address select strap
  input  wire logic                  bus_address_strap,
  // Register map access on core_clk
  output logic                       regStrobe,
  output video_i2c_pkg::reg_req_s    regReq,
  input  wire logic [7:0]            regRdData
);

  // Link domain state
  video_i2c_pkg::bus_state_e state;
  video_i2c_pkg::reg_req_s   linkReq;
  logic       sclMeta;
  logic       sclS;
  logic       sclD;
  logic       sdaMeta;
  logic       sdaS;
  logic       sdaD;
  logic       strapMeta;
  logic       strapS;
  logic [1:0] wakeCnt;
  logic       strapTaken;
  logic [6:0] devAddr;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [7:0] regPtr;
  logic [3:0] bitCnt;
  logic       reqToggle;
  logic       ackMeta;
  logic       ackS;
  logic       ackD;

  // Core domain state
  logic       reqMeta;
  logic       reqS;
  logic       reqD;
  logic       readPend;
  logic       ackToggle;
  logic [7:0] rdHold;

  // Bus event decode from the synchronised lines
  wire sclRise  = sclS & ~sclD;
  wire sclFall  = ~sclS & sclD;
  wire busStart = sclS & sclD & sdaD & ~sdaS;
  wire busStop  = sclS & sclD & ~sdaD & sdaS;
  wire byteDone = sclFall && (bitCnt == `BUS_BYTE_BITS);
  wire addrHit  = strapTaken && (rxShift[7:1] == devAddr);
  wire ackEdge  = ackS ^ ackD;
  wire reqEdge  = reqS ^ reqD;
  wire [7:0] ptrNext = regPtr + 8'h01;
  // Full 8-bit write addresses; the 7-bit device address is their top bits
  wire [7:0] addrStrapHigh = `BUS_WRITE_ADDR_STRAP_HIGH;
  wire [7:0] addrStrapLow  = `BUS_WRITE_ADDR_STRAP_LOW;

  // Two-flop synchronisers; the second stage alone feeds the delayed copy
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      sclMeta   <= 1'b1;
      sclS      <= 1'b1;
      sclD      <= 1'b1;
      sdaMeta   <= 1'b1;
      sdaS      <= 1'b1;
      sdaD      <= 1'b1;
      strapMeta <= 1'b0;
      strapS    <= 1'b0;
      ackMeta   <= 1'b0;
      ackS      <= 1'b0;
      ackD      <= 1'b0;
    end else begin
      sclMeta   <= sclIn;
      sclS      <= sclMeta;
      sclD      <= sclS;
      sdaMeta   <= sdaIn;
      sdaS      <= sdaMeta;
      sdaD      <= sdaS;
      strapMeta <= bus_address_strap;
      strapS    <= strapMeta;
      ackMeta   <= ackToggle;
      ackS      <= ackMeta;
      ackD      <= ackS;
    end
  end

  // Strap is taken once the chain has settled; the pin turns into a pixel output later
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      wakeCnt    <= 2'h0;
      strapTaken <= 1'b0;
      devAddr    <= 7'h00;
    end else if (!strapTaken) begin
      wakeCnt <= wakeCnt + 2'h1;
      if (wakeCnt == `STRAP_SETTLE_COUNT) begin
        strapTaken <= 1'b1;
        devAddr    <= strapS ? addrStrapHigh[7:1] : addrStrapLow[7:1];
      end
    end
  end

  // Every clock rise shifts in one bit and counts it
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      rxShift <= 8'h00;
    end else if (sclRise) begin
      rxShift <= {rxShift[6:0], sdaS};
    end
  end

  // Bus engine; drive changes on a seen clock fall, or on the access acknowledge while the clock is held low, so data never moves with clock high
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      state     <= video_i2c_pkg::ST_IDLE;
      bitCnt    <= 4'h0;
      sdaOe     <= 1'b0;
      sclOe     <= 1'b0;
      sdaOut    <= 1'b0;
      sclOut    <= 1'b0;
      txShift   <= 8'h00;
      regPtr    <= 8'h00;
      reqToggle <= 1'b0;
      linkReq   <= '0;
    end else begin
      if (sclRise) begin
        bitCnt <= bitCnt + 4'h1;
      end
      if (busStart) begin
        // A start (or repeated start) aborts whatever was going on
        state  <= video_i2c_pkg::ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe  <= 1'b0;
        sclOe  <= 1'b0;
      end else if (busStop) begin
        state <= video_i2c_pkg::ST_IDLE;
        sdaOe <= 1'b0;
        sclOe <= 1'b0;
      end else begin
        case (state)
          video_i2c_pkg::ST_IDLE: begin
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
          end
          video_i2c_pkg::ST_ADDR: begin
            if (byteDone) begin
              if (addrHit) begin
                sdaOe <= 1'b1;
                state <= video_i2c_pkg::ST_ADDR_ACK;
              end else begin
                state <= video_i2c_pkg::ST_IDLE;
              end
            end
          end
          video_i2c_pkg::ST_ADDR_ACK: begin
            if (sclFall) begin
              sdaOe  <= 1'b0;
              bitCnt <= 4'h0;
              if (rxShift[1]) begin
                // Direction bit sits one up, the ninth rise shifted in our own ack
                // Read address: fetch the byte at the pointer left by phase one
                reqToggle <= ~reqToggle;
                linkReq   <= '{write: 1'b0, addr: regPtr, data: 8'h00};
                sclOe     <= 1'b1;
                state     <= video_i2c_pkg::ST_RFETCH;
              end else begin
                state <= video_i2c_pkg::ST_SUB;
              end
            end
          end
          video_i2c_pkg::ST_SUB: begin
            if (byteDone) begin
              regPtr <= rxShift;
              sdaOe  <= 1'b1;
              state  <= video_i2c_pkg::ST_DATA_ACK;
            end
          end
          video_i2c_pkg::ST_DATA_ACK: begin
            if (sclFall) begin
              sdaOe  <= 1'b0;
              bitCnt <= 4'h0;
              state  <= video_i2c_pkg::ST_WDATA;
            end
          end
          video_i2c_pkg::ST_WDATA: begin
            if (byteDone) begin
              reqToggle <= ~reqToggle;
              linkReq   <= '{write: 1'b1, addr: regPtr, data: rxShift};
              sdaOe     <= 1'b1;
              sclOe     <= 1'b1;
              state     <= video_i2c_pkg::ST_WWAIT;
            end
          end
          video_i2c_pkg::ST_WWAIT: begin
            if (ackEdge) begin
              sclOe  <= 1'b0;
              regPtr <= ptrNext;
              state  <= video_i2c_pkg::ST_DATA_ACK;
            end
          end
          video_i2c_pkg::ST_RFETCH: begin
            if (ackEdge) begin
              txShift <= rdHold;
              sdaOe   <= ~rdHold[7];
              regPtr  <= ptrNext;
              sclOe   <= 1'b0;
              bitCnt  <= 4'h0;
              state   <= video_i2c_pkg::ST_RDATA;
            end
          end
          video_i2c_pkg::ST_RDATA: begin
            if (byteDone) begin
              sdaOe <= 1'b0; // Master owns the acknowledge slot
              state <= video_i2c_pkg::ST_RACK;
            end else if (sclFall) begin
              txShift <= {txShift[6:0], 1'b0};
              sdaOe   <= ~txShift[6];
            end
          end
          video_i2c_pkg::ST_RACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (rxShift[0]) begin
                state <= video_i2c_pkg::ST_IDLE;
              end else begin
                reqToggle <= ~reqToggle;
                linkReq   <= '{write: 1'b0, addr: regPtr, data: 8'h00};
                sclOe     <= 1'b1;
                state     <= video_i2c_pkg::ST_RFETCH;
              end
            end
          end
          default: begin
            state <= video_i2c_pkg::ST_IDLE;
            sdaOe <= 1'b0;
            sclOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Request toggle crossing into the core domain
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reqMeta <= 1'b0;
      reqS    <= 1'b0;
      reqD    <= 1'b0;
    end else begin
      reqMeta <= reqToggle;
      reqS    <= reqMeta;
      reqD    <= reqS;
    end
  end

  // Request word is stable while the toggle travels, so it is taken on the edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      regStrobe <= 1'b0;
      regReq    <= '0;
      readPend  <= 1'b0;
      rdHold    <= 8'h00;
      ackToggle <= 1'b0;
    end else begin
      regStrobe <= reqEdge;
      readPend  <= reqEdge & ~linkReq.write;
      if (reqEdge) begin
        regReq <= linkReq;
      end
      if (readPend) begin
        rdHold <= regRdData; // Held until the next request, read by the link side
      end
      if ((reqEdge & linkReq.write) | readPend) begin
        ackToggle <= ~ackToggle;
      end
    end
  end

endmodule // video_decoder_i2c_slave_port

`default_nettype wire

// *** verilog/video_i2c_pkg.sv ***
`default_nettype none
package video_i2c_pkg;

  // One-hot states of the bus engine
  typedef enum logic [9:0] {
    ST_IDLE     = 10'h001,
    ST_ADDR     = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_SUB      = 10'h008,
    ST_DATA_ACK = 10'h010,
    ST_WDATA    = 10'h020,
    ST_WWAIT    = 10'h040,
    ST_RFETCH   = 10'h080,
    ST_RDATA    = 10'h100,
    ST_RACK     = 10'h200
  } bus_state_e;

  // Register access handed from the link side to the register map
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_s;

endpackage

`default_nettype wire

// *** verilog/video_i2c_regs.svh ***
`ifndef VIDEO_I2C_REGS_SVH
`define VIDEO_I2C_REGS_SVH

// Bus write addresses picked by the strap; the read address is the same with bit 0 set
`define BUS_WRITE_ADDR_STRAP_LOW  8'hb8
`define BUS_WRITE_ADDR_STRAP_HIGH 8'hba

// Width of a bus byte and bit count at which the acknowledge slot starts
`define BUS_BYTE_BITS 4'h8

// Link clock edges to wait after reset before the strap level is taken
`define STRAP_SETTLE_COUNT 2'h3

`endif
